// ===== rtl/dtc_count.v
// next value and overflow of one timer counter pair for a given mode
`timescale 1ns/10ps
`default_nettype none
`include "dtc_defs.vh"

module dtc_count (
  input wire [1:0] mode_i,
  input wire inc_i,
  input wire [7:0] lo_i,
  input wire [7:0] hi_i,
  output reg [7:0] lo_o,
  output reg [7:0] hi_o,
  output reg ovf_o
);

  reg [13:0] sum13;
  reg [16:0] sum16;
  reg [8:0] sum8;

  // mode 3 here is a free running 8-bit low byte, high byte untouched
  always @*
  begin
    sum13 = {1'b0, hi_i, lo_i[4:0]} + 14'h0001;
    sum16 = {1'b0, hi_i, lo_i} + 17'h00001;
    sum8 = {1'b0, lo_i} + 9'h001;
    lo_o = lo_i;
    hi_o = hi_i;
    ovf_o = 1'b0;
    if (inc_i)
    begin
      case (mode_i)
        `DTC_MODE_13BIT:
        begin
          lo_o = {lo_i[7:5], sum13[4:0]};
          hi_o = sum13[12:5];
          ovf_o = sum13[13];
        end
        `DTC_MODE_16BIT:
        begin
          lo_o = sum16[7:0];
          hi_o = sum16[15:8];
          ovf_o = sum16[16];
        end
        `DTC_MODE_RELOAD:
        begin
          lo_o = sum8[8] ? hi_i : sum8[7:0];
          ovf_o = sum8[8];
        end
        default:
        begin
          lo_o = sum8[7:0];
          ovf_o = sum8[8];
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ===== rtl/dtc_defs.vh
// constants for the dual timer/counter block
//
// Operation
// - timer a prescaler bit 0: clear ticks at fsys/12, set ticks at fsys.
// - timer b prescaler bit 1: clear ticks at fsys/12, set ticks at fsys.
// - enable bits b at 3, a at 1; request only while the enable is set.
// - priority bits b at 3, a at 1; zero low, one high priority.
// - timer a has four modes chosen by a two-bit field in the mode register.
// - mode codes: 00 13-bit, 01 16-bit, 10 auto-reload, 11 split or stop.
// - timer a 13-bit: high byte bits 12..5, low byte 4..0, top three ignored.
// - timer a overflow sets its flag, which requests an interrupt when enabled.
// - timer a count source set counts pin falling edges, clear counts ticks.
// - timer a counts only while run is set; run never clears the count.
// - mode 1 uses all low byte bits as a full 16-bit counter.
// - timer a auto-reload: low byte wrap sets flag, reloads from high byte.
// - split mode: timer a low byte is an 8-bit counter with its own controls.
// - split mode: high byte counts ticks gated by b run, sets b flag.
// - in split mode timer b own counter holds its value.
// - timer b has 13-bit, 16-bit and auto-reload modes by its own field.
// - timer b mode 11 stops timer b counting.
// - timer b 13-bit: high byte bits 12..5, low byte 4..0, top three ignored.
// - timer b overflow sets its flag, which requests an interrupt when enabled.
// - timer b count source set counts pin falling edges, clear counts ticks.
// - setting timer b run keeps the count and resumes from it.
// - timer b mode 1 uses all low byte bits as a 16-bit counter.
// - timer b auto-reload: low byte wrap sets flag, reloads from high byte.
// - each overflow flag clears when the core vectors to its routine.
`ifndef DTC_DEFS_VH
`define DTC_DEFS_VH

// register addresses on the special function register bus
`define DTC_ADDR_CONTROL 8'h88
`define DTC_ADDR_MODE 8'h89
`define DTC_ADDR_A_LOW 8'h8a
`define DTC_ADDR_B_LOW 8'h8b
`define DTC_ADDR_A_HIGH 8'h8c
`define DTC_ADDR_B_HIGH 8'h8d
`define DTC_ADDR_PRESCALE 8'h8e
`define DTC_ADDR_IRQ_ENABLE 8'ha8
`define DTC_ADDR_IRQ_PRIORITY 8'hb8

// control register fields
`define DTC_CTL_B_FLAG 7
`define DTC_CTL_B_RUN 6
`define DTC_CTL_A_FLAG 5
`define DTC_CTL_A_RUN 4

// mode register fields
`define DTC_MODE_B_SRC 6
`define DTC_MODE_B_HI 5
`define DTC_MODE_B_LO 4
`define DTC_MODE_A_SRC 2
`define DTC_MODE_A_HI 1
`define DTC_MODE_A_LO 0

// prescale, enable and priority fields
`define DTC_PRE_A_FAST 0
`define DTC_PRE_B_FAST 1
`define DTC_IRQ_B_BIT 3
`define DTC_IRQ_A_BIT 1

// mode codes
`define DTC_MODE_13BIT 2'h0
`define DTC_MODE_16BIT 2'h1
`define DTC_MODE_RELOAD 2'h2
`define DTC_MODE_SPLIT 2'h3

// prescaler divide ratio and last count value
`define DTC_PRESCALE_DIV 4'hc
`define DTC_PRESCALE_LAST 4'hb

// reset values
`define DTC_RST_BYTE 8'h00
`define DTC_RST_BIT 1'b0

`endif

// ===== rtl/dtc_tick.v
// tick source for one timer: prescaler and count pin edge detector
`timescale 1ns/10ps
`default_nettype none
`include "dtc_defs.vh"

module dtc_tick (
  input wire clk_i,
  input wire rstn_i,
  input wire fast_sel_i,
  input wire count_src_i,
  input wire count_pin_i,
  output wire slow_tick_o,
  output wire tick_o
);

  reg [3:0] div_reg;
  reg sync1_reg;
  reg sync2_reg;
  reg last_reg;
  wire pin_fall;

  // free running divide by twelve
  always @(posedge clk_i)
  begin
    if (!rstn_i)
      div_reg <= 4'h0;
    else if (div_reg == `DTC_PRESCALE_LAST)
      div_reg <= 4'h0;
    else
      div_reg <= div_reg + 4'h1;
  end

  // two stage synchroniser and falling edge history
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      last_reg <= 1'b1;
    end
    else
    begin
      sync1_reg <= count_pin_i;
      sync2_reg <= sync1_reg;
      last_reg <= sync2_reg;
    end
  end

  assign pin_fall = last_reg & ~sync2_reg;
  // fast select bypasses the divider
  assign slow_tick_o = fast_sel_i | (div_reg == `DTC_PRESCALE_LAST);
  assign tick_o = count_src_i ? pin_fall : slow_tick_o;

endmodule

`default_nettype wire

// ===== rtl/dtc_top.v
// dual timer/counter with its special function registers
`timescale 1ns/10ps
`default_nettype none
`include "dtc_defs.vh"

module dtc_top (
  input wire clk_i,
  input wire rstn_i,
  input wire [7:0] sfr_addr_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  input wire [7:0] sfr_wdata_i,
  output wire [7:0] sfr_rdata_o,
  input wire timer_a_count_pin_i,
  input wire timer_b_count_pin_i,
  input wire timer_a_irq_ack_i,
  input wire timer_b_irq_ack_i,
  output wire timer_a_irq_o,
  output wire timer_b_irq_o,
  output wire timer_a_irq_priority_o,
  output wire timer_b_irq_priority_o
);

  // byte chosen for a counter: a core write wins over the hardware value
  function [7:0] dtc_pick;
    input wr;
    input [7:0] wdata;
    input [7:0] hw;
    begin
      if (wr)
        dtc_pick = wdata;
      else
        dtc_pick = hw;
    end
  endfunction

  // overflow flag update: a hardware set always wins over any clear
  function dtc_flag;
    input set;
    input wr;
    input wbit;
    input ack;
    input cur;
    begin
      if (set)
        dtc_flag = 1'b1;
      else if (wr)
        dtc_flag = wbit;
      else if (ack)
        dtc_flag = 1'b0;
      else
        dtc_flag = cur;
    end
  endfunction

  // register storage
  reg a_run_reg;
  reg b_run_reg;
  reg a_flag_reg;
  reg b_flag_reg;
  reg a_src_reg;
  reg b_src_reg;
  reg [1:0] a_mode_reg;
  reg [1:0] b_mode_reg;
  reg a_fast_reg;
  reg b_fast_reg;
  reg a_irq_en_reg;
  reg b_irq_en_reg;
  reg a_prio_reg;
  reg b_prio_reg;
  reg [7:0] a_lo_reg;
  reg [7:0] a_hi_reg;
  reg [7:0] b_lo_reg;
  reg [7:0] b_hi_reg;
  reg [7:0] rdata_reg;

  // next values
  reg a_flag_next;
  reg b_flag_next;
  reg [7:0] a_lo_next;
  reg [7:0] a_hi_next;
  reg [7:0] b_lo_next;
  reg [7:0] b_hi_next;
  reg [7:0] rdata_next;

  // write strobes
  wire wr_ctl;
  wire wr_mode;
  wire wr_a_lo;
  wire wr_a_hi;
  wire wr_b_lo;
  wire wr_b_hi;
  wire wr_pre;
  wire wr_ien;
  wire wr_ipr;

  // tick sources
  wire a_slow_tick;
  wire a_tick;
  wire b_tick;

  // counter engine results
  wire split_mode;
  wire a_inc;
  wire b_inc;
  wire hi_split_inc;
  wire [7:0] a_lo_hw;
  wire [7:0] a_hi_hw;
  wire a_ovf;
  wire [7:0] b_lo_hw;
  wire [7:0] b_hi_hw;
  wire b_ovf;
  wire [8:0] hi_split_sum;
  wire hi_split_ovf;

  // address decode of core writes
  assign wr_ctl = sfr_wr_i & (sfr_addr_i == `DTC_ADDR_CONTROL);
  assign wr_mode = sfr_wr_i & (sfr_addr_i == `DTC_ADDR_MODE);
  assign wr_a_lo = sfr_wr_i & (sfr_addr_i == `DTC_ADDR_A_LOW);
  assign wr_a_hi = sfr_wr_i & (sfr_addr_i == `DTC_ADDR_A_HIGH);
  assign wr_b_lo = sfr_wr_i & (sfr_addr_i == `DTC_ADDR_B_LOW);
  assign wr_b_hi = sfr_wr_i & (sfr_addr_i == `DTC_ADDR_B_HIGH);
  assign wr_pre = sfr_wr_i & (sfr_addr_i == `DTC_ADDR_PRESCALE);
  assign wr_ien = sfr_wr_i & (sfr_addr_i == `DTC_ADDR_IRQ_ENABLE);
  assign wr_ipr = sfr_wr_i & (sfr_addr_i == `DTC_ADDR_IRQ_PRIORITY);

  // timer a tick: pin edges or divided clock
  dtc_tick u_tick_a (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .fast_sel_i(a_fast_reg),
    .count_src_i(a_src_reg),
    .count_pin_i(timer_a_count_pin_i),
    .slow_tick_o(a_slow_tick),
    .tick_o(a_tick)
  );

  // timer b tick: pin edges or divided clock
  dtc_tick u_tick_b (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .fast_sel_i(b_fast_reg),
    .count_src_i(b_src_reg),
    .count_pin_i(timer_b_count_pin_i),
    .slow_tick_o(),
    .tick_o(b_tick)
  );

  // run gating for both timers
  assign split_mode = (a_mode_reg == `DTC_MODE_SPLIT);
  assign a_inc = a_run_reg & a_tick;
  // timer b holds in split mode and stops in its own mode 3
  assign b_inc = b_run_reg & b_tick & ~split_mode & (b_mode_reg != `DTC_MODE_SPLIT);
  // split high byte counts timer a's prescaler tick only, never pin edges, gated by b run
  assign hi_split_inc = split_mode & b_run_reg & a_slow_tick;

  // timer a engine; its mode 3 makes the low byte a free 8-bit counter
  dtc_count u_count_a (
    .mode_i(a_mode_reg),
    .inc_i(a_inc),
    .lo_i(a_lo_reg),
    .hi_i(a_hi_reg),
    .lo_o(a_lo_hw),
    .hi_o(a_hi_hw),
    .ovf_o(a_ovf)
  );

  // timer b engine; mode 3 never reaches it because b_inc is held low
  dtc_count u_count_b (
    .mode_i(b_mode_reg),
    .inc_i(b_inc),
    .lo_i(b_lo_reg),
    .hi_i(b_hi_reg),
    .lo_o(b_lo_hw),
    .hi_o(b_hi_hw),
    .ovf_o(b_ovf)
  );

  // split high byte incrementer
  assign hi_split_sum = {1'b0, a_hi_reg} + 9'h001;
  assign hi_split_ovf = hi_split_inc & hi_split_sum[8];

  // counter bytes: hardware update unless the core writes the byte
  always @*
  begin
    a_lo_next = dtc_pick(wr_a_lo, sfr_wdata_i, a_lo_hw);
    if (hi_split_inc)
      a_hi_next = dtc_pick(wr_a_hi, sfr_wdata_i, hi_split_sum[7:0]);
    else
      a_hi_next = dtc_pick(wr_a_hi, sfr_wdata_i, a_hi_hw);
    b_lo_next = dtc_pick(wr_b_lo, sfr_wdata_i, b_lo_hw);
    b_hi_next = dtc_pick(wr_b_hi, sfr_wdata_i, b_hi_hw);
  end

  // overflow flags: set by overflow, cleared by vectoring or a core write
  always @*
  begin
    a_flag_next = dtc_flag(a_ovf, wr_ctl, sfr_wdata_i[`DTC_CTL_A_FLAG],
                           timer_a_irq_ack_i, a_flag_reg);
    b_flag_next = dtc_flag(b_ovf | hi_split_ovf, wr_ctl, sfr_wdata_i[`DTC_CTL_B_FLAG],
                           timer_b_irq_ack_i, b_flag_reg);
  end

  // counter and flag state
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      a_lo_reg <= `DTC_RST_BYTE;
      a_hi_reg <= `DTC_RST_BYTE;
      b_lo_reg <= `DTC_RST_BYTE;
      b_hi_reg <= `DTC_RST_BYTE;
      a_flag_reg <= `DTC_RST_BIT;
      b_flag_reg <= `DTC_RST_BIT;
    end
    else
    begin
      a_lo_reg <= a_lo_next;
      a_hi_reg <= a_hi_next;
      b_lo_reg <= b_lo_next;
      b_hi_reg <= b_hi_next;
      a_flag_reg <= a_flag_next;
      b_flag_reg <= b_flag_next;
    end
  end

  // run bits; writing run leaves the counter bytes alone
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      a_run_reg <= `DTC_RST_BIT;
      b_run_reg <= `DTC_RST_BIT;
    end
    else if (wr_ctl)
    begin
      a_run_reg <= sfr_wdata_i[`DTC_CTL_A_RUN];
      b_run_reg <= sfr_wdata_i[`DTC_CTL_B_RUN];
    end
  end

  // mode register fields
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      a_src_reg <= `DTC_RST_BIT;
      b_src_reg <= `DTC_RST_BIT;
      a_mode_reg <= `DTC_MODE_13BIT;
      b_mode_reg <= `DTC_MODE_13BIT;
    end
    else if (wr_mode)
    begin
      a_src_reg <= sfr_wdata_i[`DTC_MODE_A_SRC];
      b_src_reg <= sfr_wdata_i[`DTC_MODE_B_SRC];
      a_mode_reg <= {sfr_wdata_i[`DTC_MODE_A_HI], sfr_wdata_i[`DTC_MODE_A_LO]};
      b_mode_reg <= {sfr_wdata_i[`DTC_MODE_B_HI], sfr_wdata_i[`DTC_MODE_B_LO]};
    end
  end

  // prescaler select bits
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      a_fast_reg <= `DTC_RST_BIT;
      b_fast_reg <= `DTC_RST_BIT;
    end
    else if (wr_pre)
    begin
      a_fast_reg <= sfr_wdata_i[`DTC_PRE_A_FAST];
      b_fast_reg <= sfr_wdata_i[`DTC_PRE_B_FAST];
    end
  end

  // interrupt enable bits of the two timers
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      a_irq_en_reg <= `DTC_RST_BIT;
      b_irq_en_reg <= `DTC_RST_BIT;
    end
    else if (wr_ien)
    begin
      a_irq_en_reg <= sfr_wdata_i[`DTC_IRQ_A_BIT];
      b_irq_en_reg <= sfr_wdata_i[`DTC_IRQ_B_BIT];
    end
  end

  // interrupt priority bits of the two timers
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      a_prio_reg <= `DTC_RST_BIT;
      b_prio_reg <= `DTC_RST_BIT;
    end
    else if (wr_ipr)
    begin
      a_prio_reg <= sfr_wdata_i[`DTC_IRQ_A_BIT];
      b_prio_reg <= sfr_wdata_i[`DTC_IRQ_B_BIT];
    end
  end

  // read mux; bits owned by other blocks and reserved bits read zero
  always @*
  begin
    rdata_next = 8'h00;
    case (sfr_addr_i)
      `DTC_ADDR_CONTROL:
      begin
        rdata_next[`DTC_CTL_B_FLAG] = b_flag_reg;
        rdata_next[`DTC_CTL_B_RUN] = b_run_reg;
        rdata_next[`DTC_CTL_A_FLAG] = a_flag_reg;
        rdata_next[`DTC_CTL_A_RUN] = a_run_reg;
      end
      `DTC_ADDR_MODE:
      begin
        rdata_next[`DTC_MODE_B_SRC] = b_src_reg;
        rdata_next[`DTC_MODE_B_HI] = b_mode_reg[1];
        rdata_next[`DTC_MODE_B_LO] = b_mode_reg[0];
        rdata_next[`DTC_MODE_A_SRC] = a_src_reg;
        rdata_next[`DTC_MODE_A_HI] = a_mode_reg[1];
        rdata_next[`DTC_MODE_A_LO] = a_mode_reg[0];
      end
      `DTC_ADDR_A_LOW:
        rdata_next = a_lo_reg;
      `DTC_ADDR_A_HIGH:
        rdata_next = a_hi_reg;
      `DTC_ADDR_B_LOW:
        rdata_next = b_lo_reg;
      `DTC_ADDR_B_HIGH:
        rdata_next = b_hi_reg;
      `DTC_ADDR_PRESCALE:
      begin
        rdata_next[`DTC_PRE_A_FAST] = a_fast_reg;
        rdata_next[`DTC_PRE_B_FAST] = b_fast_reg;
      end
      `DTC_ADDR_IRQ_ENABLE:
      begin
        rdata_next[`DTC_IRQ_A_BIT] = a_irq_en_reg;
        rdata_next[`DTC_IRQ_B_BIT] = b_irq_en_reg;
      end
      `DTC_ADDR_IRQ_PRIORITY:
      begin
        rdata_next[`DTC_IRQ_A_BIT] = a_prio_reg;
        rdata_next[`DTC_IRQ_B_BIT] = b_prio_reg;
      end
      default:
        rdata_next = 8'h00;
    endcase
  end

  // read data is captured on a read strobe and held until the next one
  always @(posedge clk_i)
  begin
    if (!rstn_i)
      rdata_reg <= `DTC_RST_BYTE;
    else if (sfr_rd_i)
      rdata_reg <= rdata_next;
  end

  assign sfr_rdata_o = rdata_reg;

  // interrupt requests follow the sticky flags while enabled
  assign timer_a_irq_o = a_flag_reg & a_irq_en_reg;
  assign timer_b_irq_o = b_flag_reg & b_irq_en_reg;
  assign timer_a_irq_priority_o = a_prio_reg;
  assign timer_b_irq_priority_o = b_prio_reg;

endmodule

`default_nettype wire

// ===== tb/dtc_core_model.sv
// processor core model: register bus accesses and interrupt acknowledges
`timescale 1ns/10ps
`default_nettype none
module dtc_core_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] wdata_o,
  output logic [1:0] ack_o
);
  // idle bus at time zero
  initial
  begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    ack_o = 2'h0;
  end
  // one-cycle write; released lines stop showing the old value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  // one-cycle read; data is registered at the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask
  // vector to one timer routine for a single cycle
  task automatic ack(input int t);
    @(negedge clk_i);
    ack_o[t] = 1'b1;
    @(negedge clk_i);
    ack_o[t] = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== tb/dtc_props.sv
// concurrent checks on the dual timer/counter ports
`timescale 1ns/10ps
`default_nettype none
module dtc_props (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic timer_a_irq_ack_i,
  input wire logic timer_b_irq_ack_i,
  input wire logic timer_a_irq_o,
  input wire logic timer_b_irq_o,
  input wire logic timer_a_irq_priority_o,
  input wire logic timer_b_irq_priority_o
);
  logic [7:0] en_reg;
  logic [7:0] ctl_reg;
  wire wr_ip = sfr_wr_i && sfr_addr_i == 8'hb8;
  // shadow copies of the enable register and the run bits
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      en_reg <= 8'h00;
      ctl_reg <= 8'h00;
    end
    else
    begin
      if (sfr_wr_i && sfr_addr_i == 8'ha8)
        en_reg <= sfr_wdata_i;
      if (sfr_wr_i && sfr_addr_i == 8'h88)
        ctl_reg <= sfr_wdata_i;
    end
  end
  default clocking dcb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  AST_IRQ_A_GATE: assert property (timer_a_irq_o |-> en_reg[1])
    else $error("timer a request without its enable");
  AST_IRQ_B_GATE: assert property (timer_b_irq_o |-> en_reg[3])
    else $error("timer b request without its enable");
  AST_PRIO_A: assert property (wr_ip |=> timer_a_irq_priority_o == $past(sfr_wdata_i[1]))
    else $error("timer a priority not taken from write");
  AST_PRIO_B: assert property (wr_ip ##1 !wr_ip [*3] |-> timer_b_irq_priority_o == $past(sfr_wdata_i[3], 3))
    else $error("timer b priority not held from write");
  AST_ACK_A: assert property (timer_a_irq_ack_i && !ctl_reg[4] && !sfr_wr_i |=> !timer_a_irq_o)
    else $error("timer a flag survives acknowledge");
  AST_ACK_B: assert property (timer_b_irq_ack_i && !ctl_reg[6] && !sfr_wr_i |=> !timer_b_irq_o)
    else $error("timer b flag survives acknowledge");
  AST_RISE_A: assert property ($rose(timer_a_irq_o) |-> $past(ctl_reg[4]) || $past(sfr_wr_i))
    else $error("timer a overflow while stopped");
  AST_RISE_B: assert property ($rose(timer_b_irq_o) |-> $past(ctl_reg[6]) || $past(sfr_wr_i))
    else $error("timer b overflow while stopped");
  AST_RD_EN: assert property (sfr_rd_i && sfr_addr_i == 8'ha8 |=> sfr_rdata_o == ($past(en_reg) & 8'h0a))
    else $error("enable register read back wrong");
  AST_RD_IP: assert property (sfr_rd_i && sfr_addr_i == 8'hb8 |=>
    sfr_rdata_o == {4'h0, $past(timer_b_irq_priority_o), 1'b0, $past(timer_a_irq_priority_o), 1'b0})
    else $error("priority register read back wrong");
  COV_A: cover property ($rose(timer_a_irq_o));
  COV_B: cover property ($rose(timer_b_irq_o));
  COV_ACK: cover property (timer_a_irq_ack_i && timer_a_irq_o);
endmodule
bind dtc_top dtc_props chk (.clk_i(clk_i), .rstn_i(rstn_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
  .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
  .timer_a_irq_ack_i(timer_a_irq_ack_i), .timer_b_irq_ack_i(timer_b_irq_ack_i),
  .timer_a_irq_o(timer_a_irq_o), .timer_b_irq_o(timer_b_irq_o),
  .timer_a_irq_priority_o(timer_a_irq_priority_o), .timer_b_irq_priority_o(timer_b_irq_priority_o));
`default_nettype wire

// ===== tb/test_dual_timer_counter.sv
// self-checking bench for the dual timer/counter
`timescale 1ns/10ps
`default_nettype none
module test_dual_timer_counter;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [1:0] pin = 2'h3;
  logic [7:0] addr, wdata, rdata, d;
  logic wr, rd, irq_a, irq_b, pri_a, pri_b;
  logic [1:0] ack;
  int err_total = 0;
  int checks = 0;
  int n;
  // register rows: address, value written, value read back
  logic [7:0] rows [0:11][0:2] = '{'{8'h8e, 8'hff, 8'h03}, '{8'ha8, 8'hff, 8'h0a}, '{8'hb8, 8'hff, 8'h0a},
    '{8'h89, 8'hff, 8'h77}, '{8'h8a, 8'h3c, 8'h3c}, '{8'h8b, 8'hc3, 8'hc3}, '{8'h8c, 8'h5a, 8'h5a},
    '{8'h8d, 8'ha5, 8'ha5}, '{8'h99, 8'hff, 8'h00}, '{8'hb8, 8'h00, 8'h00}, '{8'h89, 8'h00, 8'h00},
    '{8'h88, 8'h00, 8'h00}};
  always #4 clk_i = ~clk_i;
  dtc_core_model core (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .rd_o(rd),
    .wdata_o(wdata), .ack_o(ack));
  dtc_top uut (.clk_i(clk_i), .rstn_i(rstn_i), .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_rd_i(rd),
    .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .timer_a_count_pin_i(pin[0]), .timer_b_count_pin_i(pin[1]),
    .timer_a_irq_ack_i(ack[0]), .timer_b_irq_ack_i(ack[1]), .timer_a_irq_o(irq_a), .timer_b_irq_o(irq_b),
    .timer_a_irq_priority_o(pri_a), .timer_b_irq_priority_o(pri_b));
  // compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("mismatches %0d in %0d checks", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // falling edges until a request shows, bounded
  task automatic wait_hi(input int t, output int c);
    c = 0;
    while ((t ? irq_b : irq_a) !== 1'b1)
    begin
      @(negedge clk_i);
      c++;
      if (c > 60)
      begin
        err_total++;
        final_report();
      end
    end
  endtask
  // n falls on one count pin, low two cycles and high three
  task automatic pulse(input int t, input int k);
    repeat (k)
    begin
      @(negedge clk_i);
      pin[t] = 1'b0;
      repeat (2) @(negedge clk_i);
      pin[t] = 1'b1;
      repeat (3) @(negedge clk_i);
    end
  endtask
  initial
  begin
    repeat (16) @(negedge clk_i);
    rstn_i = 1'b1;
    // plain register accesses, one unmapped
    foreach (rows[i])
    begin
      core.wr(rows[i][0], rows[i][1]);
      core.rd(rows[i][0], d);
      check(d, rows[i][2]);
    end
    // priority bits reach the priority outputs
    core.wr(8'hb8, 8'h0a);
    check({6'h00, pri_b, pri_a}, 8'h03);
    // 13-bit pin counting on timer a, stopped and resumed
    core.wr(8'h89, 8'h04);
    core.wr(8'h8a, 8'h1e);
    core.wr(8'h8c, 8'h00);
    core.wr(8'h88, 8'h10);
    pulse(0, 3);
    core.wr(8'h88, 8'h00);
    pulse(0, 2);
    core.wr(8'h88, 8'h10);
    pulse(0, 1);
    core.rd(8'h8c, d);
    check(d, 8'h01);
    core.rd(8'h8a, d);
    check(d & 8'h1f, 8'h02);
    // 16-bit pin counting on timer b
    core.wr(8'h89, 8'h50);
    core.wr(8'h8b, 8'hff);
    core.wr(8'h8d, 8'h7f);
    core.wr(8'h88, 8'h40);
    pulse(1, 2);
    core.rd(8'h8b, d);
    check(d, 8'h01);
    core.rd(8'h8d, d);
    check(d, 8'h80);
    // 16-bit pin counting on timer a, 13-bit pin counting on timer b
    core.wr(8'h89, 8'h45);
    core.wr(8'h8a, 8'hff);
    core.wr(8'h8c, 8'h12);
    core.wr(8'h8b, 8'h1f);
    core.wr(8'h8d, 8'h00);
    core.wr(8'h88, 8'h50);
    pulse(0, 1);
    pulse(1, 1);
    core.rd(8'h8c, d);
    check(d, 8'h13);
    core.rd(8'h8d, d);
    check(d, 8'h01);
    // reload from 0xff overflows every tick; gap after acknowledge is ten cycles at fsys/12 and none at fsys
    for (int t = 0; t < 2; t++)
      for (int f = 0; f < 2; f++)
      begin
        core.wr(8'h88, 8'h00);
        core.wr(8'h8e, 8'(f << t));
        core.wr(8'h89, 8'h22);
        core.wr(8'(8'h8c + t), 8'hff);
        core.wr(8'(8'h8a + t), 8'hff);
        core.wr(8'h88, t ? 8'h40 : 8'h10);
        wait_hi(t, n);
        core.ack(t);
        wait_hi(t, n);
        check(8'(n), f ? 8'h00 : 8'h0a);
      end
    // split: high byte on b run raises b flag, low byte counts pin a, b counter holds
    core.wr(8'h88, 8'h00);
    core.wr(8'h8e, 8'h01);
    core.wr(8'h89, 8'h17);
    core.wr(8'h8b, 8'h55);
    core.wr(8'h8a, 8'hfe);
    core.wr(8'h8c, 8'hf0);
    core.wr(8'h88, 8'h40);
    wait_hi(1, n);
    check(8'(n), 8'h10);
    core.wr(8'h88, 8'h50);
    pulse(0, 2);
    check({7'h00, irq_a}, 8'h01);
    core.rd(8'h8a, d);
    check(d, 8'h00);
    // timer b mode 3 holds against pin falls
    core.wr(8'h89, 8'h70);
    pulse(1, 3);
    core.rd(8'h8b, d);
    check(d, 8'h55);
    // flags set by the core with both timers stopped: enable gates, acknowledge clears
    core.wr(8'h88, 8'ha0);
    check({6'h00, irq_b, irq_a}, 8'h03);
    core.wr(8'ha8, 8'h00);
    check({6'h00, irq_b, irq_a}, 8'h00);
    core.wr(8'ha8, 8'h0a);
    core.ack(0);
    check({7'h00, irq_a}, 8'h00);
    core.ack(1);
    check({7'h00, irq_b}, 8'h00);
    // reset with both timers stopped clears everything
    rstn_i = 1'b0;
    repeat (16) @(negedge clk_i);
    rstn_i = 1'b1;
    foreach (rows[i])
    begin
      core.rd(rows[i][0], d);
      check(d, 8'h00);
    end
    check({4'h0, irq_a, irq_b, pri_a, pri_b}, 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
